// ==== core/qlp_pkg.sv ====
// Shared types and constants for the quad lane parallel data port
package qlp_pkg;
	// Lane count on the transmit side (B, C, D) and on the receive side (B, C)
	localparam int TX_LANES = 3;
	localparam int RX_LANES = 2;
	localparam int WORD_W   = 10;
	localparam int FIFO_DEPTH = 16;
	// Clock indices inside the sampled transmit clock vector
	localparam int CLK_IDX_A = 0;
	// Mode bit positions inside the sampled mode vector
	localparam int MODE_SHARE = 0;
	localparam int MODE_CODEC = 1;
	// Timing: one receive step is a quarter of the receive clock period
	localparam int SYS_CLK_NS   = 25;
	localparam int RX_STEP_NS   = 50;
	localparam int RX_STEP_CYC  = (RX_STEP_NS / SYS_CLK_NS < 1) ? 1 : RX_STEP_NS / SYS_CLK_NS;
	localparam logic [3:0] RX_STEP_LAST = 4'(RX_STEP_CYC - 1);
	localparam logic [3:0] STEP_RESET   = 4'h0;
	localparam logic       LEVEL_RESET  = 1'b0;

	// One lane word as seen on the pins: bits 0-7, bit 8, bit 9
	typedef struct packed {
		logic       bit9;
		logic       bit8;
		logic [7:0] bus;
	} qlp_word_t;

	// One entry of the transmit FIFO: a lane mask and the word of each lane
	typedef struct packed {
		logic [TX_LANES-1:0]             mask;
		qlp_word_t [TX_LANES-1:0]        word;
	} qlp_tx_entry_t;

	// One received word from the core: raw code group and decoded view
	typedef struct packed {
		logic [WORD_W-1:0] code;
		logic [7:0]        data;
		logic              ctrl;
		logic              err;
	} qlp_rx_word_t;
endpackage

// ==== core/qlp_fifo.sv ====
// Synchronous FIFO with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module qlp_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [AW:0]                 count;
		logic                        outValid;
		logic [WIDTH-1:0]            outData;
	} qlp_fifo_state_t;

	qlp_fifo_state_t q;
	qlp_fifo_state_t d;
	logic            doWrite;
	logic            doRead;

	// The output register holds one word as well, so it counts toward the depth
	assign inReady  = ((q.count + (AW+1)'(q.outValid)) != (AW+1)'(DEPTH));
	assign outValid = q.outValid;
	assign outData  = q.outData;

	always_comb
	begin
		d = q;
		doWrite = inValid && inReady;
		// Refill the output register when it is empty or being taken
		doRead = (q.count != '0) && (!q.outValid || outReady);
		if (doWrite)
		begin
			d.mem[q.wrPtr] = inData;
			d.wrPtr = q.wrPtr + 1'b1;
		end
		if (doRead)
		begin
			d.outData = q.mem[q.rdPtr];
			d.rdPtr = q.rdPtr + 1'b1;
			d.outValid = 1'b1;
		end
		else if (outReady)
		begin
			d.outValid = 1'b0;
		end
		d.count = q.count + (AW+1)'(doWrite) - (AW+1)'(doRead);
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end
endmodule // qlp_fifo

// ==== core/qlp_port.sv ====
// Parallel side of lanes B, C and D: double-edge capture and receive presentation
// Functional notes
// - Own mode: capture each lane on both edges
// - Shared mode: capture all lanes on lane A
// - Own mode: receive valid on own clock edges
// - Shared mode: receive valid on lane A clock
// - Raw mode: bits 8-9 are code bits
// - Codec mode: bit 8 marks control character
// - Codec mode: transmit bit 9 is ignored
// - Raw mode: receive bits 8-9 raw code
// - Codec mode: receive bit 8 flags control
// - Codec mode: receive bit 9 flags errors
// - Shared mode: ignore B-D clocks, B-C idle
// - Codec needs both pin and enable bit
`timescale 1ns/1ps
module qlp_port (
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire logic                  clockShareSelect,
	input  wire logic                  codecEnablePin,
	input  wire logic                  codecEnableBit,
	input  wire logic                  laneATxClock,
	input  wire logic                  laneBTxClock,
	input  wire logic                  laneCTxClock,
	input  wire logic                  laneDTxClock,
	input  wire logic [7:0]            laneBTxBus,
	input  wire logic                  laneBTxBit8,
	input  wire logic                  laneBTxBit9,
	input  wire logic [7:0]            laneCTxBus,
	input  wire logic                  laneCTxBit8,
	input  wire logic                  laneCTxBit9,
	input  wire logic [7:0]            laneDTxBus,
	input  wire logic                  laneDTxBit8,
	input  wire logic                  laneDTxBit9,
	output logic                       txWordValid,
	input  wire logic                  txWordReady,
	output qlp_pkg::qlp_tx_entry_t     txWord,
	output logic                       txCodecOn,
	output logic                       txDrop,
	input  wire qlp_pkg::qlp_rx_word_t laneBRxIn,
	input  wire qlp_pkg::qlp_rx_word_t laneCRxIn,
	output logic                       rxTake,
	output logic                       laneARxClock,
	output logic                       laneBRxClock,
	output logic                       laneCRxClock,
	output logic [7:0]                 laneBRxBus,
	output logic                       laneBRxBit8,
	output logic                       laneBRxBit9,
	output logic [7:0]                 laneCRxBus,
	output logic                       laneCRxBit8,
	output logic                       laneCRxBit9
);
	typedef struct packed {
		logic [3:0]                                   txClkS1;
		logic [3:0]                                   txClkS2;
		logic [3:0]                                   txClkS3;
		qlp_pkg::qlp_word_t [qlp_pkg::TX_LANES-1:0]   txDatS1;
		qlp_pkg::qlp_word_t [qlp_pkg::TX_LANES-1:0]   txDatS2;
		logic [1:0]                                   modeS1;
		logic [1:0]                                   modeS2;
		logic [3:0]                                   stepCnt;
		logic                                         phase;
		logic                                         rxClkA;
		logic                                         rxClkB;
		logic                                         rxClkC;
		qlp_pkg::qlp_word_t [qlp_pkg::RX_LANES-1:0]   rxOut;
		logic                                         txDrop;
	} qlp_port_state_t;

	qlp_port_state_t        q;
	qlp_port_state_t        d;
	qlp_pkg::qlp_tx_entry_t entry;
	logic                   codecOn;
	logic                   shareOn;
	logic                   stepTick;
	logic                   fifoInReady;
	int                     src;

	// Transmit word as forwarded: bit 9 carries nothing while the codec runs
	function automatic qlp_pkg::qlp_word_t txFilter(input qlp_pkg::qlp_word_t w,
		input logic codec);
		qlp_pkg::qlp_word_t r;
		r = w;
		if (codec)
			r.bit9 = 1'b0;
		return r;
	endfunction

	// Receive word as presented: raw code group or decoded byte with flags
	function automatic qlp_pkg::qlp_word_t rxView(input qlp_pkg::qlp_rx_word_t w,
		input logic codec);
		qlp_pkg::qlp_word_t r;
		if (codec)
		begin
			r.bus  = w.data;
			r.bit8 = w.ctrl;
			r.bit9 = w.err;
		end
		else
		begin
			r = w.code;
		end
		return r;
	endfunction

	assign shareOn  = q.modeS2[qlp_pkg::MODE_SHARE];
	assign codecOn  = q.modeS2[qlp_pkg::MODE_CODEC] && codecEnableBit;
	assign stepTick = (q.stepCnt == qlp_pkg::RX_STEP_LAST);
	assign rxTake   = stepTick && !q.phase;

	always_comb
	begin
		d = q;
		entry = '0;
		src = 0;
		d.txClkS1 = {laneDTxClock, laneCTxClock, laneBTxClock, laneATxClock};
		d.txClkS2 = q.txClkS1;
		d.txClkS3 = q.txClkS2;
		d.txDatS1 = {{laneDTxBit9, laneDTxBit8, laneDTxBus},
			{laneCTxBit9, laneCTxBit8, laneCTxBus},
			{laneBTxBit9, laneBTxBit8, laneBTxBus}};
		d.txDatS2 = q.txDatS1;
		d.modeS1 = {codecEnablePin, clockShareSelect};
		d.modeS2 = q.modeS1;
		// Capture on any change of the selected clock, rising or falling
		for (int i = 0; i < qlp_pkg::TX_LANES; i++)
		begin
			src = shareOn ? qlp_pkg::CLK_IDX_A : i + 1;
			if (q.txClkS2[src] != q.txClkS3[src])
			begin
				entry.mask[i] = 1'b1;
				entry.word[i] = txFilter(q.txDatS2[i], codecOn);
			end
		end
		d.txDrop = (entry.mask != '0) && !fifoInReady;
		// Receive steps alternate: new data, then a clock edge mid-word
		if (stepTick)
		begin
			d.stepCnt = qlp_pkg::STEP_RESET;
			d.phase = !q.phase;
			if (!q.phase)
			begin
				d.rxOut[0] = rxView(laneBRxIn, codecOn);
				d.rxOut[1] = rxView(laneCRxIn, codecOn);
			end
			else
			begin
				d.rxClkA = !q.rxClkA;
				d.rxClkB = shareOn ? qlp_pkg::LEVEL_RESET : !q.rxClkB;
				d.rxClkC = shareOn ? qlp_pkg::LEVEL_RESET : !q.rxClkC;
			end
		end
		else
		begin
			d.stepCnt = q.stepCnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	qlp_fifo #(
		.WIDTH ($bits(qlp_pkg::qlp_tx_entry_t)),
		.DEPTH (qlp_pkg::FIFO_DEPTH)
	) txFifo (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.inValid  (entry.mask != '0),
		.inReady  (fifoInReady),
		.inData   (entry),
		.outValid (txWordValid),
		.outReady (txWordReady),
		.outData  (txWord)
	);

	assign txCodecOn    = codecOn;
	assign txDrop       = q.txDrop;
	assign laneARxClock = q.rxClkA;
	assign laneBRxClock = q.rxClkB;
	assign laneCRxClock = q.rxClkC;
	assign laneBRxBus   = q.rxOut[0].bus;
	assign laneBRxBit8  = q.rxOut[0].bit8;
	assign laneBRxBit9  = q.rxOut[0].bit9;
	assign laneCRxBus   = q.rxOut[1].bus;
	assign laneCRxBit8  = q.rxOut[1].bit8;
	assign laneCRxBit9  = q.rxOut[1].bit9;
endmodule // qlp_port

// ==== verif/qlp_port_assertions.sv ====
// Port checker for the quad lane parallel data port
`timescale 1ns/1ps
module qlp_port_assertions (
	input wire logic                   sys_clk,
	input wire logic                   rstn,
	input wire logic                   clockShareSelect,
	input wire logic                   codecEnablePin,
	input wire logic                   codecEnableBit,
	input wire logic                   txWordValid,
	input wire logic                   txWordReady,
	input wire qlp_pkg::qlp_tx_entry_t txWord,
	input wire logic                   txCodecOn,
	input wire logic                   txDrop,
	input wire qlp_pkg::qlp_rx_word_t  laneBRxIn,
	input wire logic                   rxTake,
	input wire logic                   laneARxClock,
	input wire logic                   laneBRxClock,
	input wire logic [7:0]             laneBRxBus,
	input wire logic                   laneBRxBit8,
	input wire logic                   laneBRxBit9
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence takeGap;
		rxTake ##1 !rxTake [*3];
	endsequence
	sequence clkQuiet;
		$stable(laneARxClock) [*2];
	endsequence
	a_codec_needs_bit: assert property (txCodecOn == (codecEnableBit && $past(codecEnablePin, 2)))
		else $error("codec active without enable bit");
	a_share_rx_low: assert property (clockShareSelect [*8] |-> !laneBRxClock)
		else $error("lane B rx clock moves in shared mode");
	a_raw_rx_map: assert property (rxTake && !txCodecOn |=>
		{laneBRxBit9, laneBRxBit8, laneBRxBus} == $past(laneBRxIn.code))
		else $error("raw receive word wrong");
	a_codec_rx_map: assert property (rxTake && txCodecOn |=> laneBRxBus ==
		$past(laneBRxIn.data) && laneBRxBit8 == $past(laneBRxIn.ctrl) && laneBRxBit9 == $past(laneBRxIn.err))
		else $error("decoded receive word wrong");
	a_rx_data_hold: assert property (!rxTake |=> $stable(laneBRxBus))
		else $error("receive data changed between takes");
	a_rx_take_gap: assert property (takeGap |=> rxTake)
		else $error("receive take spacing wrong");
	a_rx_clk_edge: assert property (rxTake |=> clkQuiet ##1 $changed(laneARxClock))
		else $error("receive clock edge not centred on data");
	a_tx_hold: assert property (txWordValid && !txWordReady |=> txWordValid && $stable(txWord))
		else $error("transmit entry not held");
	a_tx_drop_full: assert property (txDrop |-> $past(txWordValid))
		else $error("drop while FIFO not full");
endmodule // qlp_port_assertions
bind qlp_port qlp_port_assertions u_chk (.sys_clk, .rstn, .clockShareSelect, .codecEnablePin,
	.codecEnableBit,
	.txWordValid, .txWordReady, .txWord, .txCodecOn, .txDrop, .laneBRxIn, .rxTake,
	.laneARxClock, .laneBRxClock, .laneBRxBus, .laneBRxBit8, .laneBRxBit9);

// ==== verif/qlp_host_model.sv ====
// Parallel host model: lane transmit clocks and words
`timescale 1ns/1ps
module qlp_host_model (
	output logic [3:0]                txClk,
	output qlp_pkg::qlp_word_t [2:0]  word
);
	initial
	begin
		txClk = 4'h0;
		word = '0;
	end
	// Word is set 50 ns before the edge and held 50 ns after it
	task automatic send(input int base, input int n, input logic share, input logic [2:0] m);
		for (int i = base; i < base + n; i++)
		begin
			for (int l = 0; l < 3; l++)
				word[l] <= {i[1:0], 8'(i * 5 + l)};
			#50;
			txClk <= txClk ^ (share ? 4'h1 : {m, 1'b0});
			#25;
			txClk[1] <= txClk[1] ^ share;
			#25;
		end
		word <= ~word;
	endtask
endmodule // qlp_host_model

// ==== verif/qlp_port_tb_top.sv ====
// Testbench for the quad lane parallel data port
`timescale 1ns/1ps
module qlp_port_tb_top;
	typedef struct { logic s, p, b; logic [2:0] m; } qlp_row_t;
	qlp_row_t rows [5] = '{'{0,0,0,7}, '{0,0,0,3}, '{1,0,0,0}, '{0,1,1,7}, '{0,1,0,5}};
	logic sys_clk = 0, rstn = 0, share = 0, cPin = 0, cBit = 0, txWordReady = 0;
	logic txWordValid, txDrop, rxTake, txCodecOn;
	logic [3:0] txClk;
	logic [2:0] rxClk;
	qlp_pkg::qlp_word_t [2:0] word;
	qlp_pkg::qlp_word_t rxWB, rxWC;
	qlp_pkg::qlp_tx_entry_t txWord;
	qlp_pkg::qlp_rx_word_t rxB = '0, rxC = '0;
	int n_mismatch = 0, num_checks = 0, drops = 0, nx = 0;
	qlp_host_model host (.txClk, .word);
	qlp_port dut (.sys_clk, .rstn, .clockShareSelect(share), .codecEnablePin(cPin),
		.codecEnableBit(cBit), .laneATxClock(txClk[0]), .laneBTxClock(txClk[1]),
		.laneCTxClock(txClk[2]), .laneDTxClock(txClk[3]), .laneBTxBus(word[0].bus),
		.laneBTxBit8(word[0].bit8), .laneBTxBit9(word[0].bit9), .laneCTxBus(word[1].bus),
		.laneCTxBit8(word[1].bit8), .laneCTxBit9(word[1].bit9), .laneDTxBus(word[2].bus),
		.laneDTxBit8(word[2].bit8), .laneDTxBit9(word[2].bit9), .txWordValid, .txWordReady,
		.txWord, .txCodecOn, .txDrop, .laneBRxIn(rxB), .laneCRxIn(rxC), .rxTake,
		.laneARxClock(rxClk[0]), .laneBRxClock(rxClk[1]), .laneCRxClock(rxClk[2]),
		.laneBRxBus(rxWB.bus), .laneBRxBit8(rxWB.bit8), .laneBRxBit9(rxWB.bit9),
		.laneCRxBus(rxWC.bus), .laneCRxBit8(rxWC.bit8), .laneCRxBit9(rxWC.bit9));
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) drops <= drops + txDrop;
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic qlp_pkg::qlp_word_t rxExp(qlp_pkg::qlp_rx_word_t x, logic c);
		return c ? {x.err, x.ctrl, x.data} : x.code;
	endfunction
	task automatic drain(input int base, input int n, input qlp_row_t r);
		logic [2:0] m;
		m = r.s ? 3'h7 : r.m;
		for (int i = base; i < base + n; i++)
		begin
			@(negedge sys_clk);
			chk("txMask", {1'b1, m}, {txWordValid, txWord.mask});
			for (int l = 0; l < 3; l++)
				if (m[l])
					chk("txWord", {i[1] & !(r.p & r.b), i[0], 8'(i * 5 + l)}, txWord.word[l]);
			@(posedge sys_clk);
			txWordReady <= 1'h1;
			@(posedge sys_clk);
			txWordReady <= 1'h0;
			repeat (2) @(posedge sys_clk);
		end
		@(negedge sys_clk);
		chk("txEmpty", 0, txWordValid);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		results();
	end
	initial
	begin
		repeat (3) @(negedge sys_clk);
		chk("resetOut", 0, {txWordValid, rxClk, rxWB, rxWC});
		@(posedge sys_clk);
		rstn <= 1'h1;
		foreach (rows[k])
		begin
			@(posedge sys_clk);
			share <= rows[k].s;
			cPin <= rows[k].p;
			cBit <= rows[k].b;
			rxB <= {10'(k * 99 + 5), 8'(k * 37 + 3), k[0], !k[0]};
			rxC <= {10'(k * 45 + 9), 8'(k * 11 + 6), !k[0], k[0]};
			repeat (8) @(posedge sys_clk);
			host.send(nx, 4, rows[k].s, rows[k].m);
			repeat (8) @(posedge sys_clk);
			drain(nx, 4, rows[k]);
			nx += 4;
			chk("codecOn", rows[k].p & rows[k].b, txCodecOn);
			chk("rxB", rxExp(rxB, rows[k].p & rows[k].b), rxWB);
			chk("rxC", rxExp(rxC, rows[k].p & rows[k].b), rxWC);
			if (rows[k].s)
				chk("rxClkBC", 0, rxClk[2:1]);
			$display("row %0d done", k);
		end
		host.send(nx, 18, 1'h0, 3'h7);
		repeat (8) @(posedge sys_clk);
		chk("drops", 2, drops);
		drain(nx, 16, rows[0]);
		nx += 18;
		$display("overflow done");
		host.send(nx, 3, 1'h0, 3'h7);
		@(posedge sys_clk);
		rstn <= 1'h0;
		repeat (2) @(negedge sys_clk);
		chk("resetValid", 0, txWordValid);
		@(posedge sys_clk);
		rstn <= 1'h1;
		$display("reset done");
		results();
	end
endmodule // qlp_port_tb_top
